// ==== src/cimc_ctrl.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// - Sequence register steps, branches, or vectors.
// - Any of four sources sets indicator.
// - Indicator seen: save status, jump vector.
// - Return restores status, resumes exact point.
// - Console press interrupts; source readable.
// - Monitor call raises external interrupt.
// - Protected violation raises internal interrupt.
// - Internal waits until external routine ends.
// - Address field two, three, four characters.
// - Address register prefixes short field.
// - Item-mark trap selected by mode instruction.
// - Trapped item-marked op branches to location.
// - Addresses cover up to 1,048,576 locations.
// - Six-bit character locations, one per cycle.
module cimc_ctrl #(
   parameter int ADDR_W = cimc_pkg::ADDR_W
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Interrupt sources
   input wire logic periph_irq,
   input wire logic console_btn,
   input wire logic monitor_call,
   input wire logic protect_en,
   input wire logic protect_violation,
   input wire logic nonexist_access,
   // Instruction stream
   input wire logic instr_boundary,
   input wire logic branch_taken,
   input wire logic [ADDR_W-1:0] branch_target,
   input wire logic [2:0] instr_len,
   input wire logic item_mark_op,
   input wire logic return_from_irq,
   input wire logic read_source,
   // Mode instruction
   input wire logic change_addressing_mode_instr,
   input wire logic [1:0] mode_sel,
   input wire logic trap_sel,
   // Address formation
   input wire logic addr_reg_load,
   input wire logic [ADDR_W-1:0] addr_reg_value,
   input wire logic [ADDR_W-1:0] addr_field,
   input wire logic [ADDR_W-1:0] mem_size_m1,
   // Status outputs
   output logic [ADDR_W-1:0] seq_q,
   output logic [ADDR_W-1:0] eff_addr_q,
   output logic addr_oob_q,
   output logic irq_indicator_q,
   output logic in_ext_service_q,
   output logic in_int_service_q,
   output logic [cimc_pkg::NUM_SRC-1:0] source_q,
   output logic change_sequencing_mode_instr,
   output logic [1:0] amode_q,
   output logic trap_en_q
);

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers for pins from outside

   logic [2:0] btn_sync_q;
   logic btn_level_q;
   logic btn_press;

   // Three stages; only stages two and three are compared
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         btn_sync_q <= 3'h0;
         btn_level_q <= 1'b0;
      end else begin
         btn_sync_q <= {btn_sync_q[1:0], console_btn};
         if (btn_sync_q[1] == btn_sync_q[2]) begin
            btn_level_q <= btn_sync_q[2];
         end
      end
   end

   assign btn_press = btn_sync_q[1] & btn_sync_q[2] & ~btn_level_q;

   logic [2:0] per_sync_q;
   logic per_level_q;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         per_sync_q <= 3'h0;
         per_level_q <= 1'b0;
      end else begin
         per_sync_q <= {per_sync_q[1:0], periph_irq};
         if (per_sync_q[1] == per_sync_q[2]) begin
            per_level_q <= per_sync_q[2];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pending interrupt latches

   logic ext_pend_q;
   logic int_pend_q;
   logic prot_event;
   logic ext_event;
   cimc_pkg::cimc_state_t state_q;
   logic take_ext;
   logic take_int;
   logic [ADDR_W-1:0] saved_seq_q;
   logic [ADDR_W-1:0] seq_next;
   logic [1:0] saved_amode_q;
   logic saved_trap_q;
   logic [ADDR_W-1:0] addr_reg_q;

   assign prot_event = protect_en & (protect_violation | nonexist_access);
   assign ext_event = per_level_q | btn_press | monitor_call;

   // internal only when no external routine runs
   assign take_ext = (state_q == cimc_pkg::CIMC_RUN) & instr_boundary & ext_pend_q & ~in_ext_service_q;
   assign take_int = (state_q == cimc_pkg::CIMC_RUN) & instr_boundary & int_pend_q & ~ext_pend_q &
                     ~in_ext_service_q & ~in_int_service_q;

   // sticky until taken; a new event beats the clear
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ext_pend_q <= 1'b0;
      end else if (ext_event) begin
         ext_pend_q <= 1'b1;
      end else if (take_ext) begin
         ext_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         int_pend_q <= 1'b0;
      end else if (prot_event) begin
         int_pend_q <= 1'b1;
      end else if (take_int) begin
         int_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         irq_indicator_q <= 1'b0;
      end else begin
         irq_indicator_q <= ext_event | prot_event | (ext_pend_q & ~take_ext) | (int_pend_q & ~take_int);
      end
   end

   // source kept readable, cleared by the read
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         source_q <= '0;
      end else begin
         source_q[cimc_pkg::SRC_PERIPH] <= per_level_q | (source_q[cimc_pkg::SRC_PERIPH] & ~read_source);
         source_q[cimc_pkg::SRC_CONSOLE] <= btn_press | (source_q[cimc_pkg::SRC_CONSOLE] & ~read_source);
         source_q[cimc_pkg::SRC_MONITOR] <= monitor_call | (source_q[cimc_pkg::SRC_MONITOR] & ~read_source);
         source_q[cimc_pkg::SRC_PROTECT] <= prot_event | (source_q[cimc_pkg::SRC_PROTECT] & ~read_source);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt entry and return sequence

   logic pick_ext_q;

   // Save one cycle, serve until return, restore one cycle
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_q <= cimc_pkg::CIMC_RUN;
         pick_ext_q <= 1'b0;
      end else begin
         unique case (state_q)
            cimc_pkg::CIMC_RUN: begin
               if (take_ext || take_int) begin
                  state_q <= cimc_pkg::CIMC_SAVE;
                  pick_ext_q <= take_ext;
               end
            end
            cimc_pkg::CIMC_SAVE: begin
               state_q <= cimc_pkg::CIMC_SERVE;
            end
            cimc_pkg::CIMC_SERVE: begin
               if (return_from_irq && instr_boundary) begin
                  state_q <= cimc_pkg::CIMC_RESTORE;
               end
            end
            cimc_pkg::CIMC_RESTORE: begin
               state_q <= cimc_pkg::CIMC_RUN;
            end
         endcase
      end
   end

   // Service flags; no nesting, a single save area
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         in_ext_service_q <= 1'b0;
         in_int_service_q <= 1'b0;
      end else if (state_q == cimc_pkg::CIMC_SAVE) begin
         in_ext_service_q <= pick_ext_q;
         in_int_service_q <= ~pick_ext_q;
      end else if (state_q == cimc_pkg::CIMC_RESTORE) begin
         in_ext_service_q <= 1'b0;
         in_int_service_q <= 1'b0;
      end
   end

   // resume after the completed instruction
   // Saving the current address would run a finished instruction twice
   assign seq_next = branch_taken ? branch_target : seq_q + ADDR_W'(instr_len);

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         saved_seq_q <= cimc_pkg::START_ADDR;
         saved_amode_q <= cimc_pkg::AMODE_RESET;
         saved_trap_q <= 1'b0;
      end else if (take_ext || take_int) begin
         saved_seq_q <= seq_next;
         saved_amode_q <= amode_q;
         saved_trap_q <= trap_en_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequence register

   // Trap replaces an item-marked op with a sequencing-mode change
   logic trap_hit;
   assign trap_hit = trap_en_q & item_mark_op & instr_boundary & (state_q != cimc_pkg::CIMC_SAVE) &
                     (state_q != cimc_pkg::CIMC_RESTORE) & ~take_ext & ~take_int;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         seq_q <= cimc_pkg::START_ADDR;
      end else if (state_q == cimc_pkg::CIMC_SAVE) begin
         seq_q <= pick_ext_q ? cimc_pkg::EXT_VECTOR_RESET : cimc_pkg::INT_VECTOR_RESET;
      end else if (state_q == cimc_pkg::CIMC_RESTORE) begin
         seq_q <= saved_seq_q;
      // trapped op goes to fixed location
      end else if (trap_hit) begin
         seq_q <= cimc_pkg::TRAP_VECTOR_RESET;
      end else if (instr_boundary && !take_ext && !take_int) begin
         seq_q <= seq_next;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         change_sequencing_mode_instr <= 1'b0;
      end else begin
         change_sequencing_mode_instr <= trap_hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode register and address formation

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         amode_q <= cimc_pkg::AMODE_RESET;
         trap_en_q <= 1'b0;
      end else if (state_q == cimc_pkg::CIMC_RESTORE) begin
         amode_q <= saved_amode_q;
         trap_en_q <= saved_trap_q;
      end else if (change_addressing_mode_instr) begin
         // Reserved code keeps the current width
         if (mode_sel != 2'h3) begin
            amode_q <= mode_sel;
         end
         trap_en_q <= trap_sel;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         addr_reg_q <= cimc_pkg::START_ADDR;
      end else if (addr_reg_load) begin
         addr_reg_q <= addr_reg_value;
      end
   end

   // Upper bits from the address register, low bits from the field; four-character mode takes all bits from the field
   function automatic logic [ADDR_W-1:0] cimc_form(input logic [1:0] mode, input logic [ADDR_W-1:0] pre,
                                                   input logic [ADDR_W-1:0] fld);
      logic [ADDR_W-1:0] m;
      m = '1;
      if (mode == cimc_pkg::AMODE_2CHAR) begin
         m = (ADDR_W'(1) << cimc_pkg::FIELD_2CHAR_W) - ADDR_W'(1);
      end else if (mode == cimc_pkg::AMODE_3CHAR) begin
         m = (ADDR_W'(1) << cimc_pkg::FIELD_3CHAR_W) - ADDR_W'(1);
      end
      return (pre & ~m) | (fld & m);
   endfunction

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         eff_addr_q <= cimc_pkg::START_ADDR;
         addr_oob_q <= 1'b0;
      end else begin
         eff_addr_q <= cimc_form(amode_q, addr_reg_q, addr_field);
         addr_oob_q <= cimc_form(amode_q, addr_reg_q, addr_field) > mem_size_m1;
      end
   end

endmodule

// ==== src/cimc_pkg.sv ====
package cimc_pkg;

   // Address geometry
   localparam int ADDR_W = 20;
   localparam int CHAR_W = 6;
   localparam logic [ADDR_W-1:0] MEM_MAX_LOCS_M1 = 20'hfffff;
   localparam logic [ADDR_W-1:0] MEM_MIN_LOCS = 20'h0c000;

   // Addressing mode codes
   localparam logic [1:0] AMODE_2CHAR = 2'h0;
   localparam logic [1:0] AMODE_3CHAR = 2'h1;
   localparam logic [1:0] AMODE_4CHAR = 2'h2;
   localparam logic [1:0] AMODE_RESET = 2'h1;

   // Field widths per mode, in address bits
   localparam int FIELD_2CHAR_W = 12;
   localparam int FIELD_3CHAR_W = 15;

   // Source codes for the pending-source register
   localparam int SRC_PERIPH = 0;
   localparam int SRC_CONSOLE = 1;
   localparam int SRC_MONITOR = 2;
   localparam int SRC_PROTECT = 3;
   localparam int NUM_SRC = 4;

   // Interrupt and trap vectors, start address
   localparam logic [ADDR_W-1:0] EXT_VECTOR_RESET = 20'h00100;
   localparam logic [ADDR_W-1:0] INT_VECTOR_RESET = 20'h00200;
   localparam logic [ADDR_W-1:0] TRAP_VECTOR_RESET = 20'h00300;
   localparam logic [ADDR_W-1:0] START_ADDR = 20'h00000;

   // Control states
   typedef enum logic [3:0] {
      CIMC_RUN = 4'h1,
      CIMC_SAVE = 4'h2,
      CIMC_SERVE = 4'h4,
      CIMC_RESTORE = 4'h8
   } cimc_state_t;

endpackage

// ==== tb/cimc_ctrl_chk.sv ====
`timescale 1ns/10ps
module cimc_ctrl_chk #(
   parameter int ADDR_W = cimc_pkg::ADDR_W
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Inputs of the block
   input wire logic monitor_call,
   input wire logic instr_boundary,
   input wire logic branch_taken,
   input wire logic [ADDR_W-1:0] branch_target,
   input wire logic [2:0] instr_len,
   input wire logic item_mark_op,
   input wire logic change_addressing_mode_instr,
   input wire logic [1:0] mode_sel,
   input wire logic trap_sel,
   input wire logic addr_reg_load,
   input wire logic [ADDR_W-1:0] addr_reg_value,
   input wire logic [ADDR_W-1:0] addr_field,
   // Outputs of the block
   input wire logic [ADDR_W-1:0] seq_q,
   input wire logic [ADDR_W-1:0] eff_addr_q,
   input wire logic irq_indicator_q,
   input wire logic in_ext_service_q,
   input wire logic in_int_service_q,
   input wire logic change_sequencing_mode_instr,
   input wire logic [1:0] amode_q,
   input wire logic trap_en_q
);
   logic [ADDR_W-1:0] pre_q, sav_q, fmask, exp_a;
   logic pre_ok_q, svc;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   assign svc = in_ext_service_q | in_int_service_q;

   // Prefix copy; its reset value is unknown, so wait for a load
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pre_ok_q <= 1'b0;
      end else if (addr_reg_load) begin
         pre_ok_q <= 1'b1;
         pre_q <= addr_reg_value;
      end
   end

   // Resume point: the instruction after the one completing at the take
   always_ff @(posedge mclk) begin
      if (instr_boundary && irq_indicator_q && !svc) begin
         sav_q <= branch_taken ? branch_target : seq_q + ADDR_W'(instr_len);
      end
   end

   // Field bits per mode, the rest from the prefix
   always_comb begin
      fmask = '1;
      if (amode_q == cimc_pkg::AMODE_2CHAR) begin
         fmask = (ADDR_W'(1) << cimc_pkg::FIELD_2CHAR_W) - ADDR_W'(1);
      end else if (amode_q == cimc_pkg::AMODE_3CHAR) begin
         fmask = (ADDR_W'(1) << cimc_pkg::FIELD_3CHAR_W) - ADDR_W'(1);
      end
      exp_a = (pre_q & ~fmask) | (addr_field & fmask);
   end

   ////////////////////////////////////////////////////////////////
   chk_mon_pend: assert property (monitor_call |=> irq_indicator_q)
      else $error("monitor call left indicator clear");
   chk_take_entry: assert property (instr_boundary && irq_indicator_q && !svc |-> ##2 svc)
      else $error("pending request not taken");
   chk_ext_vector: assert property ($rose(in_ext_service_q) |-> seq_q == cimc_pkg::EXT_VECTOR_RESET)
      else $error("external entry off vector");
   chk_int_rank: assert property ($rose(in_int_service_q) |-> !$past(in_ext_service_q))
      else $error("internal entry inside external service");
   chk_resume_point: assert property ($fell(svc) |-> ##[0:1] seq_q == sav_q)
      else $error("return missed the saved point");
   chk_mode_load: assert property (change_addressing_mode_instr && mode_sel != 2'h3
         |=> amode_q == $past(mode_sel) && trap_en_q == $past(trap_sel))
      else $error("mode instruction not applied");
   chk_trap_jump: assert property (instr_boundary && item_mark_op && trap_en_q && !irq_indicator_q && !svc
         |=> change_sequencing_mode_instr && seq_q == cimc_pkg::TRAP_VECTOR_RESET)
      else $error("trapped op did not branch");
   chk_addr_form: assert property (pre_ok_q && !addr_reg_load && !change_addressing_mode_instr
         |=> eff_addr_q == $past(exp_a))
      else $error("formed address wrong");
endmodule

bind cimc_ctrl cimc_ctrl_chk #(.ADDR_W(ADDR_W)) u_chk (.mclk, .rst_n, .monitor_call, .instr_boundary, .branch_taken,
   .branch_target, .instr_len, .item_mark_op,
   .change_addressing_mode_instr, .mode_sel, .trap_sel, .addr_reg_load, .addr_reg_value, .addr_field, .seq_q,
   .eff_addr_q, .irq_indicator_q, .in_ext_service_q, .in_int_service_q, .change_sequencing_mode_instr, .amode_q,
   .trap_en_q);

// ==== tb/cimc_far_mdl.sv ====
`timescale 1ns/10ps
module cimc_far_mdl (
   // Clock and commands
   input wire logic mclk,
   input wire logic periph_req,
   input wire logic press,
   // Requests toward the processor
   output logic periph_irq,
   output logic console_btn
);
   logic [2:0] hold_q = 3'h0;
   assign periph_irq = periph_req;
   // console press held
   // Held long enough for the three-stage synchroniser
   always @(posedge mclk) begin
      if (press) begin
         hold_q <= 3'h5;
      end else if (hold_q != 3'h0) begin
         hold_q <= hold_q - 3'h1;
      end
   end
   assign console_btn = (hold_q != 3'h0);
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
   localparam logic [6:0] MON = 7'h01, PV = 7'h02, NE = 7'h04, BD = 7'h08, RD = 7'h10, MODE = 7'h20, ARL = 7'h40;
   logic mclk = 1'b0, rst_n = 1'b0, periph_req = 1'b0, press = 1'b0, protect_en = 1'b0;
   logic branch_taken = 1'b0, item_mark_op = 1'b0, return_from_irq = 1'b0;
   logic [2:0] instr_len = 3'h1;
   logic [6:0] pls = 7'h0;
   logic [19:0] d = 20'h0, mem_size_m1 = 20'h0bfff;
   logic periph_irq, console_btn, addr_oob_q, irq_indicator_q, in_ext_service_q, in_int_service_q;
   logic change_sequencing_mode_instr, trap_en_q;
   logic [1:0] amode_q;
   logic [3:0] source_q;
   logic [19:0] seq_q, eff_addr_q, sv;
   int fails = 0;
   int checks_done = 0;

   always #5 mclk = ~mclk;

   cimc_far_mdl far (.mclk, .periph_req, .press, .periph_irq, .console_btn);
   // One shared data word feeds target, prefix, field and mode
   cimc_ctrl dut (.mclk, .rst_n, .periph_irq, .console_btn, .monitor_call(pls[0]), .protect_en,
      .protect_violation(pls[1]), .nonexist_access(pls[2]), .instr_boundary(pls[3]), .branch_taken,
      .branch_target(d), .instr_len, .item_mark_op, .return_from_irq, .read_source(pls[4]),
      .change_addressing_mode_instr(pls[5]), .mode_sel(d[1:0]), .trap_sel(d[2]), .addr_reg_load(pls[6]),
      .addr_reg_value(d), .addr_field(d), .mem_size_m1, .seq_q, .eff_addr_q, .addr_oob_q, .irq_indicator_q,
      .in_ext_service_q, .in_int_service_q, .source_q, .change_sequencing_mode_instr, .amode_q, .trap_en_q);

   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One-cycle pulse with its qualifiers; returns after the sampling edge
   task automatic go(input logic [6:0] p, input logic [19:0] v = 20'h0, input logic [2:0] l = 3'h1,
         input logic b = 1'b0, input logic im = 1'b0, input logic rt = 1'b0);
      @(posedge mclk);
      pls <= p;
      d <= v;
      instr_len <= l;
      branch_taken <= b;
      item_mark_op <= im;
      return_from_irq <= rt;
      @(posedge mclk);
      pls <= 7'h0;
      #1;
   endtask

   task automatic conclude;
      $display("Checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Run needs well under 400 cycles
   initial begin
      #20000;
      fails++;
      conclude();
   end

   ////////////////////////////////////////////////////////////////
   initial begin
      logic [19:0] mk;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      #1;
      chk(amode_q, 20'h1);
      chk(seq_q, 20'h0);
      go(BD, 20'h0, 3'h3);
      chk(seq_q, 20'h3);
      go(BD, 20'h01234, 3'h1, 1'b1);
      chk(seq_q, 20'h01234);
      $display("Test sequencing done");
      // Trap bit alternates; reserved code 3 keeps the width only
      for (int m = 0; m < 4; m++) begin
         go(MODE, 20'(m) | (20'(m % 2) << 2));
         chk(amode_q, (m == 3) ? 20'h2 : 20'(m));
         chk(trap_en_q, 20'(m % 2));
      end
      go(MODE, 20'h5);
      go(BD, 20'h0, 3'h1, 1'b0, 1'b1);
      chk(change_sequencing_mode_instr, 20'h1);
      chk(seq_q, cimc_pkg::TRAP_VECTOR_RESET);
      go(MODE, 20'h1);
      go(BD, 20'h0, 3'h1, 1'b0, 1'b1);
      chk(seq_q, 20'h00301);
      $display("Test modes done");
      go(ARL, 20'habcde);
      for (int m = 0; m < 3; m++) begin
         mk = (20'h1 << ((m == 0) ? cimc_pkg::FIELD_2CHAR_W : (m == 1) ? cimc_pkg::FIELD_3CHAR_W : 20)) - 20'h1;
         go(MODE, 20'(m));
         go(7'h0, 20'h12345);
         chk(eff_addr_q, (20'habcde & ~mk) | (20'h12345 & mk));
         chk(addr_oob_q, 20'h1);
      end
      go(7'h0, 20'h0bfff);
      chk(addr_oob_q, 20'h0);
      $display("Test addressing done");
      go(PV | NE);
      chk(irq_indicator_q, 20'h0);
      @(posedge mclk);
      protect_en <= 1'b1;
      go(MON);
      chk(irq_indicator_q, 20'h1);
      sv = seq_q;
      // Taking boundary advances two characters; resume lands past it
      go(BD, 20'h0, 3'h2);
      go(7'h0);
      chk(in_ext_service_q, 20'h1);
      chk(seq_q, cimc_pkg::EXT_VECTOR_RESET);
      chk(irq_indicator_q, 20'h0);
      go(PV);
      go(BD);
      go(7'h0);
      chk(in_int_service_q, 20'h0);
      chk(source_q, 20'hc);
      go(RD);
      chk(source_q, 20'h0);
      go(BD, 20'h0, 3'h1, 1'b0, 1'b0, 1'b1);
      go(7'h0);
      chk(in_ext_service_q, 20'h0);
      chk(seq_q, sv + 20'h2);
      go(BD);
      go(7'h0);
      chk(in_int_service_q, 20'h1);
      chk(seq_q, cimc_pkg::INT_VECTOR_RESET);
      go(BD, 20'h0, 3'h1, 1'b0, 1'b0, 1'b1);
      go(7'h0);
      chk(seq_q, sv + 20'h3);
      chk(amode_q, 20'h2);
      $display("Test interrupts done");
      @(posedge mclk);
      press <= 1'b1;
      periph_req <= 1'b1;
      @(posedge mclk);
      press <= 1'b0;
      repeat (8) @(posedge mclk);
      #1;
      chk(source_q, 20'h3);
      chk(irq_indicator_q, 20'h1);
      $display("Test far side done");
      conclude();
   end
endmodule
